// >>> design/atsc_pkg.sv
// Summary of operation
// - converter tick rate is pclk divided by divider_value plus one
// - divider_enable low stops the converter tick, high runs it
// - one conversion takes five converter ticks
// - conversion_done_flag reads 0 while converting, 1 when finished
// - input_channel_select picks inputs 0-3 or pads ym, yp, xm, xp
// - standby_select halts conversion and keeps both results
// - with start-on-read set, a result read launches a conversion
// - start trigger bit begins conversion, self-clears, ignored under start-on-read
// - x measurement stores into x result then raises touch_interrupt
// - y measurement stores into y result then raises touch_interrupt
// - auto mode stores x, then y, then raises one interrupt
// - wait-for-stylus mode raises touch_interrupt on the selected stylus event
// - stylus_edge_select chooses pen-down (0) or pen-up (1) event
// - ym and xm switches enable at 1; yp, xp, pull-up at 0
// - position_select: 00 none, 01 x, 10 y, 11 wait-for-stylus
// - auto_sequence 1 selects x-then-y sequencing, 0 normal
// - x: xp ref, xm gnd, y float, sample yp; y swapped, sample xp
// - idle touch pads serve as analog inputs four to seven
// - x result holds x or normal value in bits 9:0
// - y result holds y value in bits 9:0
// - status bit 1 records stylus-up, bit 0 stylus-down
// - 16-bit delay precedes each conversion; zero must not be used
package atsc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 32'h0580_0000;
    localparam logic [ADDR_W-1:0] OFS_PAD = 32'h0580_0004;
    localparam logic [ADDR_W-1:0] OFS_DELAY = 32'h0580_0008;
    localparam logic [ADDR_W-1:0] OFS_XRES = 32'h0580_000C;
    localparam logic [ADDR_W-1:0] OFS_YRES = 32'h0580_0010;
    localparam logic [ADDR_W-1:0] OFS_STAT = 32'h0580_0014;
    localparam logic [15:0] RST_CTRL = 16'h3FC4;
    localparam logic [8:0] RST_PAD = 9'h058;
    localparam logic [15:0] RST_DELAY = 16'h00FF;
    localparam logic [2:0] CONV_TICKS = 3'h5;
    localparam logic [1:0] POS_NONE = 2'h0;
    localparam logic [1:0] POS_X = 2'h1;
    localparam logic [1:0] POS_Y = 2'h2;
    localparam logic [1:0] POS_WAIT = 2'h3;
    localparam logic [2:0] SEL_YP = 3'h5;
    localparam logic [2:0] SEL_XP = 3'h7;
    localparam int STAT_UP = 1;
    localparam int STAT_DN = 0;

    typedef struct packed {
        logic conversion_done_flag;
        logic divider_enable;
        logic [7:0] divider_value;
        logic [2:0] input_channel_select;
        logic standby_select;
        logic read_start;
        logic start_trigger;
    } atsc_ctrl_s;

    typedef struct packed {
        logic stylus_edge_select;
        logic y_minus_switch;
        logic y_plus_switch;
        logic x_minus_switch;
        logic x_plus_switch;
        logic x_plus_pullup;
        logic auto_sequence;
        logic [1:0] position_select;
    } atsc_pad_s;

    typedef struct packed {
        logic x_plus_drive;
        logic x_minus_drive;
        logic y_plus_drive;
        logic y_minus_drive;
        logic x_plus_pullup;
    } atsc_drive_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DELAY = 3'b010,
        ST_CONV = 3'b100
    } atsc_state_e;
endpackage

// >>> design/atsc_top.sv
`timescale 1ns/10ps
module atsc_top
    import atsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] converter_data,
    input wire logic stylus_pressed,
    output logic converter_tick,
    output logic [2:0] channel_select,
    output atsc_drive_s pad_drive,
    output logic touch_interrupt
);
    atsc_ctrl_s ctrl_r;
    atsc_pad_s pad_r;
    atsc_state_e st_r;
    logic [15:0] delay_r;
    logic [15:0] dly_cnt_r;
    logic [7:0] div_cnt_r;
    logic [2:0] tick_cnt_r;
    logic [9:0] x_res_r;
    logic [9:0] y_res_r;
    logic [1:0] stat_r;
    logic y_phase_r;
    logic stylus_prev_r;
    logic pready_r;
    logic [DATA_W-1:0] prdata_r;
    logic pslverr_r;
    logic tick_r;
    logic irq_r;
    logic [2:0] chan_r;
    atsc_drive_s drive_r;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    // two-cycle access: first access cycle prepares data, second completes
    logic acc_prep;
    logic acc_wr;
    logic acc_rd;
    assign acc_prep = psel & penable & ~pready_r;
    assign acc_wr = psel & penable & pready_r & pwrite;
    assign acc_rd = psel & penable & pready_r & ~pwrite;

    logic mapped;
    assign mapped = hit(paddr, OFS_CTRL) | hit(paddr, OFS_PAD) | hit(paddr, OFS_DELAY)
        | hit(paddr, OFS_XRES) | hit(paddr, OFS_YRES) | hit(paddr, OFS_STAT);

    logic auto_md;
    logic meas_x;
    logic meas_y;
    logic busy;
    assign auto_md = pad_r.auto_sequence;
    assign busy = (st_r != ST_IDLE);
    assign meas_x = busy & (auto_md ? ~y_phase_r : (pad_r.position_select == POS_X));
    assign meas_y = busy & (auto_md ? y_phase_r : (pad_r.position_select == POS_Y));

    logic rd_launch;
    logic go;
    logic store;
    logic store_final;
    assign rd_launch = acc_rd & ctrl_r.read_start & (hit(paddr, OFS_XRES) | hit(paddr, OFS_YRES));
    assign go = (st_r == ST_IDLE) & ~ctrl_r.standby_select
        & ((ctrl_r.start_trigger & ~ctrl_r.read_start) | rd_launch);
    assign store = (st_r == ST_CONV) & tick_r & (tick_cnt_r == CONV_TICKS - 3'h1)
        & ~ctrl_r.standby_select;
    assign store_final = store & ~(auto_md & ~y_phase_r);

    logic set_trig;
    assign set_trig = acc_wr & hit(paddr, OFS_CTRL) & pwdata[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= acc_prep;
            pslverr_r <= acc_prep & ~mapped;
            prdata_r <= 32'h0000_0000;
            if (acc_prep) begin
                if (hit(paddr, OFS_CTRL)) begin
                    prdata_r <= {16'h0000, ctrl_r};
                end else if (hit(paddr, OFS_PAD)) begin
                    prdata_r <= {23'h00_0000, pad_r};
                end else if (hit(paddr, OFS_DELAY)) begin
                    prdata_r <= {16'h0000, delay_r};
                end else if (hit(paddr, OFS_XRES)) begin
                    prdata_r <= {16'h0000, ~stylus_pressed, auto_md, pad_r.position_select,
                        2'h0, x_res_r};
                end else if (hit(paddr, OFS_YRES)) begin
                    prdata_r <= {16'h0000, ~stylus_pressed, auto_md, pad_r.position_select,
                        2'h0, y_res_r};
                end else if (hit(paddr, OFS_STAT)) begin
                    prdata_r <= {30'h0000_0000, stat_r};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= RST_CTRL;
        end else begin
            if (acc_wr & hit(paddr, OFS_CTRL)) begin
                ctrl_r.divider_enable <= pwdata[14];
                ctrl_r.divider_value <= pwdata[13:6];
                ctrl_r.input_channel_select <= pwdata[5:3];
                ctrl_r.standby_select <= pwdata[2];
                ctrl_r.read_start <= pwdata[1];
            end
            if (set_trig) begin
                ctrl_r.start_trigger <= 1'b1;
            end else if (go) begin
                ctrl_r.start_trigger <= 1'b0;
            end
            // clear at start, set at final store
            if (store_final) begin
                ctrl_r.conversion_done_flag <= 1'b1;
            end else if (go) begin
                ctrl_r.conversion_done_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_r <= RST_PAD;
            delay_r <= RST_DELAY;
        end else begin
            if (acc_wr & hit(paddr, OFS_PAD)) begin
                pad_r <= pwdata[8:0];
            end
            if (acc_wr & hit(paddr, OFS_DELAY)) begin
                delay_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end else if (!ctrl_r.divider_enable) begin
            div_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end else if (div_cnt_r >= ctrl_r.divider_value) begin
            div_cnt_r <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    // conversion sequencer; a stalled divider simply stalls the conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            dly_cnt_r <= 16'h0000;
            tick_cnt_r <= 3'h0;
            y_phase_r <= 1'b0;
        end else if (ctrl_r.standby_select) begin
            st_r <= ST_IDLE;
            y_phase_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (go) begin
                        st_r <= ST_DELAY;
                        dly_cnt_r <= delay_r;
                        y_phase_r <= 1'b0;
                    end
                end
                ST_DELAY: begin
                    // zero delay treated as one cycle
                    if (dly_cnt_r <= 16'h0001) begin
                        st_r <= ST_CONV;
                        tick_cnt_r <= 3'h0;
                    end else begin
                        dly_cnt_r <= dly_cnt_r - 16'h0001;
                    end
                end
                ST_CONV: begin
                    if (store) begin
                        // auto: x phase then y phase
                        if (auto_md & ~y_phase_r) begin
                            y_phase_r <= 1'b1;
                            st_r <= ST_DELAY;
                            dly_cnt_r <= delay_r;
                        end else begin
                            y_phase_r <= 1'b0;
                            st_r <= ST_IDLE;
                        end
                    end else if (tick_r) begin
                        tick_cnt_r <= tick_cnt_r + 3'h1;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_res_r <= 10'h000;
            y_res_r <= 10'h000;
        end else if (store) begin
            if (meas_y) begin
                y_res_r <= converter_data;
            end else begin
                // x and normal land in x result
                x_res_r <= converter_data;
            end
        end
    end

    logic wait_md;
    logic ev_dn;
    logic ev_up;
    logic conv_irq;
    assign wait_md = ~auto_md & (pad_r.position_select == POS_WAIT);
    assign ev_dn = wait_md & ~pad_r.stylus_edge_select & stylus_pressed & ~stylus_prev_r;
    assign ev_up = wait_md & pad_r.stylus_edge_select & ~stylus_pressed & stylus_prev_r;
    assign conv_irq = store_final & (auto_md | (pad_r.position_select == POS_X)
        | (pad_r.position_select == POS_Y));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stylus_prev_r <= 1'b0;
            stat_r <= 2'h0;
            irq_r <= 1'b0;
        end else begin
            stylus_prev_r <= stylus_pressed;
            irq_r <= conv_irq | ev_dn | ev_up;
            // event status, set wins over clear
            for (int i = 0; i < 2; i++) begin
                if ((i == STAT_UP) ? ev_up : ev_dn) begin
                    stat_r[i] <= 1'b1;
                end else if (acc_wr & hit(paddr, OFS_STAT) & pwdata[i]) begin
                    stat_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_r <= 3'h0;
            drive_r <= 5'h00;
        end else if (meas_x) begin
            // x: xp ref, xm gnd, sample yp
            chan_r <= SEL_YP;
            drive_r <= 5'b11000;
        end else if (meas_y) begin
            // y: yp ref, ym gnd, sample xp
            chan_r <= SEL_XP;
            drive_r <= 5'b00110;
        end else begin
            // selected input, pads as inputs 4-7
            chan_r <= ctrl_r.input_channel_select;
            drive_r.x_plus_drive <= ~pad_r.x_plus_switch;
            drive_r.x_minus_drive <= pad_r.x_minus_switch;
            drive_r.y_plus_drive <= ~pad_r.y_plus_switch;
            drive_r.y_minus_drive <= pad_r.y_minus_switch;
            drive_r.x_plus_pullup <= ~pad_r.x_plus_pullup;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign converter_tick = tick_r;
    assign channel_select = chan_r;
    assign pad_drive = drive_r;
    assign touch_interrupt = irq_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [7:0] gap_r;
    logic clean_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 8'h00;
            clean_r <= 1'b0;
        end else begin
            gap_r <= tick_r ? 8'h00 : gap_r + 8'h01;
            if (acc_wr & hit(paddr, OFS_CTRL)) begin
                clean_r <= 1'b0;
            end else if (tick_r) begin
                clean_r <= 1'b1;
            end
        end
    end

    property p_div_period;
        tick_r && clean_r |-> gap_r == ctrl_r.divider_value;
    endproperty
    a_div_period: assert property (p_div_period) else $error("tick period wrong");

    property p_div_off;
        !ctrl_r.divider_enable |=> !tick_r;
    endproperty
    a_div_off: assert property (p_div_off) else $error("tick while disabled");

    property p_five_ticks;
        store |-> tick_cnt_r == 3'h4 && tick_r;
    endproperty
    a_five_ticks: assert property (p_five_ticks) else $error("store not on fifth tick");

    property p_done_clear;
        go |=> !ctrl_r.conversion_done_flag && st_r == ST_DELAY;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared at start");

    property p_done_set;
        store_final |=> ctrl_r.conversion_done_flag && st_r == ST_IDLE;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set at store");

    property p_trig_clear;
        go && !set_trig |=> !ctrl_r.start_trigger;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

    property p_standby;
        ctrl_r.standby_select |=> st_r == ST_IDLE && $stable(x_res_r) && $stable(y_res_r);
    endproperty
    a_standby: assert property (p_standby) else $error("activity in standby");

    property p_read_start;
        rd_launch && st_r == ST_IDLE && !ctrl_r.standby_select |=> st_r == ST_DELAY;
    endproperty
    a_read_start: assert property (p_read_start) else $error("read did not start");

    sequence s_x_store;
        store && meas_x && !auto_md && pad_r.position_select == POS_X;
    endsequence
    sequence s_irq_next;
        ##1 touch_interrupt && x_res_r == $past(converter_data);
    endsequence
    property p_x_irq;
        s_x_store |-> s_irq_next;
    endproperty
    a_x_irq: assert property (p_x_irq) else $error("x store without interrupt");

    sequence s_auto_x;
        store && auto_md && !y_phase_r;
    endsequence
    property p_auto_hold;
        s_auto_x |=> !touch_interrupt && y_phase_r && st_r == ST_DELAY;
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("auto irq after x only");

    property p_pen_down;
        ev_dn |=> touch_interrupt && stat_r[STAT_DN];
    endproperty
    a_pen_down: assert property (p_pen_down) else $error("pen down not reported");

    property p_x_pads;
        meas_x |=> channel_select == SEL_YP && pad_drive == 5'b11000;
    endproperty
    a_x_pads: assert property (p_x_pads) else $error("x pad setup wrong");
endmodule

// >>> test/atsc_panel_model.sv
`timescale 1ns/10ps
module atsc_panel_model
    import atsc_pkg::*;
(
    input wire logic pclk,
    input wire logic [2:0] channel_select,
    input wire atsc_drive_s pad_drive,
    input wire logic [6:0] level,
    input wire logic press,
    output logic [9:0] converter_data,
    output logic stylus_pressed
);
    // sample names routed input
    // channel rides in the top bits so a wrong route shows in the result
    assign converter_data = {channel_select, level};

    // contact needs pull-up
    // contact only reaches the detector with ym grounded and xp pulled up
    always @(posedge pclk) begin
        stylus_pressed <= press & pad_drive.y_minus_drive & pad_drive.x_plus_pullup;
    end
endmodule

// >>> test/adc_touch_screen_control_test.sv
`timescale 1ns/10ps
module adc_touch_screen_control_test
    import atsc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd, old;
    logic [9:0] converter_data;
    logic stylus_pressed, converter_tick, touch_interrupt, press;
    logic [2:0] channel_select, sl;
    logic [6:0] level;
    logic [7:0] dv;
    logic [8:0] v;
    atsc_drive_s pad_drive;
    int miscompares, cmp_count, irq_cnt, tick_cnt, p, i0;
    logic [31:0] rst_tab [4] = '{32'h0000_3FC4, 32'h0000_0058, 32'h0000_00FF, 32'h0000_0000};
    logic [31:0] ofs_tab [4] = '{OFS_CTRL, OFS_PAD, OFS_DELAY, OFS_STAT};
    logic [8:0] mode_tab [3] = '{9'h001, 9'h002, 9'h004};

    atsc_top atsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .converter_data(converter_data), .stylus_pressed(stylus_pressed), .converter_tick(converter_tick),
        .channel_select(channel_select), .pad_drive(pad_drive), .touch_interrupt(touch_interrupt));

    atsc_panel_model atsc_panel_model_i (.pclk(pclk), .channel_select(channel_select), .pad_drive(pad_drive),
        .level(level), .press(press), .converter_data(converter_data), .stylus_pressed(stylus_pressed));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // pulses last one cycle, so count them rather than poll over the bus
    always @(posedge pclk) begin
        if (touch_interrupt === 1'b1) irq_cnt++;
        if (converter_tick === 1'b1) tick_cnt++;
    end

    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // entered just after a rising edge; one idle edge after release
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no cycle limit here: only the watchdog ends a hung wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        check("pready wait", 32'h1, 32'(n));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] ctl(logic en, logic [7:0] d, logic [2:0] s, logic [2:0] low);
        return {16'h0000, 1'b0, en, d, s, low};
    endfunction

    function automatic logic [31:0] sample(logic [2:0] s, logic [6:0] lv);
        return {22'h0, s, lv};
    endfunction

    task automatic wait_done();
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, OFS_CTRL, 32'h0);
            if (rd[15] === 1'b1) break;
        end
    endtask

    task automatic tick_period();
        for (int i = 0; i < 300 && converter_tick !== 1'b1; i++) @(posedge pclk);
        @(posedge pclk);
        p = 1;
        while (converter_tick !== 1'b1 && p < 300) begin
            @(posedge pclk);
            p++;
        end
    endtask

    initial begin
        #(50 * 30000);
        miscompares++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hc453));
        {psel, penable, pwrite, paddr, pwdata, level, press, presetn} = '0;
        {miscompares, cmp_count, irq_cnt, tick_cnt} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ofs_tab[i], 32'h0);
            check("reset value", rst_tab[i], rd);
        end
        apb(1'b0, OFS_STAT + 32'h4, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        for (int i = 0; i < 4; i++) begin
            v = {9'($urandom) & 9'h1F8};
            apb(1'b1, OFS_PAD, {23'h0, v});
            apb(1'b0, OFS_PAD, 32'h0);
            check("pad readback", {23'h0, v}, rd);
            check("pad drive", {27'h0, ~v[4], v[5], ~v[6], v[7], ~v[3]}, {27'h0, pad_drive});
        end
        apb(1'b1, OFS_PAD, 32'h0000_0058);
        for (int k = 0; k < 3; k++) begin
            dv = 8'($urandom_range(5, 8));
            sl = 3'($urandom_range(0, 7));
            level <= 7'($urandom);
            i0 = irq_cnt;
            apb(1'b1, OFS_DELAY, 32'($urandom_range(1, 6)));
            apb(1'b1, OFS_CTRL, ctl(1'b1, dv, sl, 3'b001));
            apb(1'b0, OFS_CTRL, 32'h0);
            check("busy flag", 32'h0, {31'h0, rd[15]});
            check("trigger cleared", 32'h0, {31'h0, rd[0]});
            tick_period();
            check("tick period", 32'(dv) + 32'h1, 32'(p));
            wait_done();
            check("done flag", 32'h1, {31'h0, rd[15]});
            apb(1'b0, OFS_XRES, 32'h0);
            check("x result", sample(sl, level), {22'h0, rd[9:0]});
            check("no irq", 32'(i0), 32'(irq_cnt));
        end
        for (int m = 0; m < 3; m++) begin
            level <= 7'($urandom);
            i0 = irq_cnt;
            apb(1'b1, OFS_PAD, {23'h0, 9'h058 | mode_tab[m]});
            apb(1'b1, OFS_CTRL, ctl(1'b1, 8'h05, 3'h0, 3'b001));
            tick_period();
            check("channel", {29'h0, (m == 1) ? SEL_XP : SEL_YP}, {29'h0, channel_select});
            check("drive", (m == 1) ? 32'h06 : 32'h18, {27'h0, pad_drive});
            wait_done();
            repeat (3) @(posedge pclk);
            check("irq count", 32'(i0 + 1), 32'(irq_cnt));
            if (m != 1) begin
                apb(1'b0, OFS_XRES, 32'h0);
                check("x position", sample(SEL_YP, level), {22'h0, rd[9:0]});
            end
            if (m != 0) begin
                apb(1'b0, OFS_YRES, 32'h0);
                check("y position", sample(SEL_XP, level), {22'h0, rd[9:0]});
            end
        end
        apb(1'b1, OFS_PAD, 32'h0000_0058);
        apb(1'b1, OFS_CTRL, ctl(1'b1, 8'h05, 3'h3, 3'b011));
        // read back well inside one conversion time so a wrong start shows
        apb(1'b0, OFS_CTRL, 32'h0);
        check("trigger ignored", 32'h1, {31'h0, rd[15]});
        check("trigger pending", 32'h1, {31'h0, rd[0]});
        level <= ~level;
        apb(1'b0, OFS_XRES, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        check("read launch", 32'h0, {31'h0, rd[15]});
        wait_done();
        apb(1'b1, OFS_CTRL, ctl(1'b1, 8'h05, 3'h3, 3'b000));
        apb(1'b0, OFS_XRES, 32'h0);
        check("read result", sample(3'h3, level), {22'h0, rd[9:0]});
        old = rd;
        apb(1'b1, OFS_DELAY, 32'h0000_0014);
        level <= ~level;
        apb(1'b1, OFS_CTRL, ctl(1'b1, 8'h05, 3'h2, 3'b001));
        apb(1'b1, OFS_CTRL, ctl(1'b1, 8'h05, 3'h2, 3'b100));
        repeat (60) @(posedge pclk);
        apb(1'b0, OFS_XRES, 32'h0);
        check("standby result", {22'h0, old[9:0]}, {22'h0, rd[9:0]});
        apb(1'b1, OFS_CTRL, ctl(1'b0, 8'h05, 3'h2, 3'b001));
        // let a tick launched at the write edge be counted first
        @(posedge pclk);
        i0 = tick_cnt;
        repeat (40) @(posedge pclk);
        check("ticks stopped", 32'(i0), 32'(tick_cnt));
        apb(1'b1, OFS_CTRL, ctl(1'b1, 8'h05, 3'h2, 3'b000));
        wait_done();
        apb(1'b0, OFS_XRES, 32'h0);
        check("resumed result", sample(3'h2, level), {22'h0, rd[9:0]});
        apb(1'b1, OFS_PAD, 32'h0000_00D3);
        // drive pins follow the pad register one cycle later
        @(posedge pclk);
        check("wait drive", 32'h03, {27'h0, pad_drive});
        i0 = irq_cnt;
        press <= 1'b1;
        repeat (6) @(posedge pclk);
        check("down irq", 32'(i0 + 1), 32'(irq_cnt));
        apb(1'b0, OFS_STAT, 32'h0);
        check("down status", 32'h1, rd);
        apb(1'b0, OFS_XRES, 32'h0);
        check("stylus and mode bits", 32'h3, {28'h0, rd[15:12]});
        apb(1'b1, OFS_STAT, 32'h3);
        apb(1'b1, OFS_PAD, 32'h0000_01D3);
        press <= 1'b0;
        repeat (6) @(posedge pclk);
        check("up irq", 32'(i0 + 2), 32'(irq_cnt));
        apb(1'b0, OFS_STAT, 32'h0);
        check("up status", 32'h2, rd);
        apb(1'b1, OFS_PAD, 32'h0000_0058);
        report_and_stop();
    end
endmodule
